// ==== core/tsr_pkg.sv ====
// Shared constants and types of the temperature sensor serial register block
package tsr_pkg;
  // Read addresses
  localparam logic [7:0] RD_LOCAL      = 8'h00;
  localparam logic [7:0] RD_REM_UP     = 8'h01;
  localparam logic [7:0] RD_STATUS     = 8'h02;
  localparam logic [7:0] RD_CONFIG     = 8'h03;
  localparam logic [7:0] RD_RATE       = 8'h04;
  localparam logic [7:0] RD_LHIGH      = 8'h05;
  localparam logic [7:0] RD_LLOW       = 8'h06;
  localparam logic [7:0] RD_RHIGH_UP   = 8'h07;
  localparam logic [7:0] RD_RLOW_UP    = 8'h08;
  localparam logic [7:0] RD_REM_LO     = 8'h10;
  localparam logic [7:0] RD_MAKER      = 8'hFE;
  localparam logic [7:0] RD_REVISION   = 8'hFF;
  // Write-only addresses
  localparam logic [7:0] WR_CONFIG     = 8'h09;
  localparam logic [7:0] WR_RATE       = 8'h0A;
  localparam logic [7:0] WR_LHIGH      = 8'h0B;
  localparam logic [7:0] WR_LLOW       = 8'h0C;
  localparam logic [7:0] WR_RHIGH_UP   = 8'h0D;
  localparam logic [7:0] WR_RLOW_UP    = 8'h0E;
  localparam logic [7:0] WR_ONESHOT    = 8'h0F;
  // Same-address read and write
  localparam logic [7:0] RW_OFS_UP     = 8'h11;
  localparam logic [7:0] RW_OFS_LO     = 8'h12;
  localparam logic [7:0] RW_RHIGH_LO   = 8'h13;
  localparam logic [7:0] RW_RLOW_LO    = 8'h14;
  localparam logic [7:0] RW_RCRIT      = 8'h19;
  localparam logic [7:0] RW_LCRIT      = 8'h20;
  localparam logic [7:0] RW_HYST       = 8'h21;
  localparam logic [7:0] RW_FILTER     = 8'hBF;
  // Reset values
  localparam logic [7:0] RST_ZERO      = 8'h00;
  localparam logic [7:0] RST_RATE      = 8'h08;
  localparam logic [7:0] RST_HIGH      = 8'h46;
  localparam logic [7:0] RST_RCRIT     = 8'h6E;
  localparam logic [7:0] RST_LCRIT     = 8'h55;
  localparam logic [4:0] RST_HYST      = 5'h0A;
  // Field positions and defined-bit masks
  localparam int         CFG_QUEUE     = 0;
  localparam int         CFG_LMASK     = 2;
  localparam int         CFG_RMASK     = 4;
  localparam int         CFG_STANDBY   = 6;
  localparam int         CFG_AMASK     = 7;
  localparam logic [7:0] CFG_DEFINED   = 8'hD5;
  localparam logic [7:0] FILT_DEFINED  = 8'h07;
  localparam int         FILT_LSB      = 1;
  localparam logic [1:0] QUEUE_LAST    = 2'h2;
  // Timing
  localparam int         TIMEOUT_MS    = 35;
  localparam int         MCLK_HZ       = 40000000;
  localparam int         TIMEOUT_CYC   = TIMEOUT_MS * (MCLK_HZ / 1000);

  typedef enum logic [3:0] {
    LS_ADDR      = 4'b0000,
    LS_ADDR_ACK  = 4'b0001,
    LS_CMD       = 4'b0010,
    LS_CMD_ACK   = 4'b0011,
    LS_WDATA     = 4'b0100,
    LS_WDATA_ACK = 4'b0101,
    LS_RDATA     = 4'b0110,
    LS_RDATA_ACK = 4'b0111,
    LS_IGNORE    = 4'b1000
  } link_state_type;

  typedef struct packed {
    logic [7:0] pointer;
    logic [7:0] data;
  } write_req_type;

  typedef struct packed {
    logic busy;
    logic lhigh;
    logic llow;
    logic rhigh;
    logic rlow;
    logic open;
    logic rcrit;
    logic lcrit;
  } status_type;
endpackage

// ==== core/temp_sensor_smbus_regs.sv ====
// Serial slave front end, register map and reading path of the temperature sensor
`timescale 1ns/1ps
// How it works
// - Either bus line low past 35 ms returns the serial machine to idle.
// - A start anywhere abandons the transfer; the next byte is an address.
// - Filter code 00 none, 01 and 10 level one, 11 level two.
// - Filtering smooths noise only and never shifts the settled reading.
// - With the queue on, remote alarms need three consecutive out-of-limit samples.
// - Fault queue off after reset; bit 0 of the 09h write enables it.
// - Writing address 0Fh starts a one-shot conversion; no read address.
// - In standby a one-shot runs exactly one conversion, then standby again.
// - One-shot data byte is dropped; reading 0Fh gives zero.
// - The command byte of a write loads the register pointer.
// - Readings and status at 00h, 01h, 02h, 10h are read-only, reset zero.
// - Settings read at 03h-08h and are written at 09h-0Eh.
// - Reset loads rate 08h, high limits 46h, low limits zero.
// - Offset bytes 11h and 12h read and write in place, reset zero.
// - Remote limit low bytes 13h and 14h read and write in place, reset zero.
// - Filter setup at BFh reads and writes in place, resets to zero.
// - Maker code at FEh and die revision at FFh are read-only.
// - Pointer resets to 00h and holds the last value written.
// - The signed offset is added to each remote measurement.
// - Critical limits reset to 85 local and 110 remote.
// - Critical hysteresis is five bits, resetting to 10.
module temp_sensor_smbus_regs #(
  parameter int unsigned TIMEOUT_CYCLES = tsr_pkg::TIMEOUT_CYC,
  parameter logic [6:0]  SLAVE_ADDR     = 7'h4C,
  parameter logic [7:0]  MAKER_CODE     = 8'h5A,  // Arbitrary value
  parameter logic [7:0]  REVISION_CODE  = 8'hA5   // Arbitrary value
) (
  // System clock and reset
  input  wire logic        I_MCLK,
  input  wire logic        I_RESET_N,
  // Serial link
  input  wire logic        I_SMBCLK,
  input  wire logic        I_SMBDATA,
  output logic             O_SMBDATA_OUT,
  output logic             O_SMBDATA_OE,
  // Converter side
  input  wire logic        I_SAMPLE_VALID,
  input  wire logic [7:0]  I_LOCAL_SAMPLE,
  input  wire logic [10:0] I_REMOTE_SAMPLE,
  input  wire logic        I_REMOTE_OPEN,
  output logic             O_CONVERT_REQ,
  // Open-drain alarm pins
  output logic             O_ALERT_OUT,
  output logic             O_ALERT_OE,
  output logic             O_TCRIT_OUT,
  output logic             O_TCRIT_OE
);
  localparam int CNT_W = $clog2(TIMEOUT_CYCLES + 1);

  tsr_pkg::link_state_type state;
  tsr_pkg::write_req_type  wr_req;
  tsr_pkg::status_type     status;
  logic [2:0]       bit_cnt;
  logic [7:0]       shift, tx, ptr_byte, wr_byte, read_byte, next_read_byte;
  logic             rw, ptr_tgl, wr_tgl, link_clear, in_frame, refresh, wr_valid;
  logic [1:0]       scl_sync, sda_sync;
  logic             start_flag, stop_flag, start_det, stop_det, line_low, timeout_hit;
  logic [2:0]       start_sync, stop_sync;
  logic [CNT_W-1:0] low_cnt;
  logic [2:0]       ptr_sync, wr_sync;
  logic             ptr_evt, wr_evt, drive_level, oneshot_pending;
  logic [7:0]       pointer, config_reg, conv_rate, lhigh_lim, llow_lim, rhigh_up, rlow_up;
  logic [7:0]       ofs_up, ofs_lo, rhigh_lo, rlow_lo, rcrit_lim, lcrit_lim, filter_setup;
  logic [4:0]       hyst;
  logic [7:0]       local_temp;
  logic [10:0]      remote_filt, remote_adj, next_remote;
  logic [11:0]      adj_sum, diff, step;
  logic [1:0]       fault_cnt;
  logic             r_high, r_low, r_crit, r_any, l_high, l_low, l_crit;

  // Link side: bit engine on the rising serial clock, cleared by frame events
  always_ff @(posedge I_SMBCLK or posedge link_clear) begin
    if (link_clear) begin
      state    <= tsr_pkg::LS_ADDR;
      bit_cnt  <= 3'h0;
      shift    <= 8'h00;
      tx       <= 8'h00;
      rw       <= 1'b0;
      ptr_tgl  <= 1'b0;
      wr_tgl   <= 1'b0;
      ptr_byte <= 8'h00;
      wr_byte  <= 8'h00;
    end else begin
      shift   <= {shift[6:0], I_SMBDATA};
      bit_cnt <= 3'(bit_cnt + 3'h1);
      case (state)
        tsr_pkg::LS_ADDR: begin
          if (bit_cnt == 3'h7) begin
            rw    <= I_SMBDATA;
            state <= (shift[6:0] == SLAVE_ADDR) ? tsr_pkg::LS_ADDR_ACK : tsr_pkg::LS_IGNORE;
          end
        end
        tsr_pkg::LS_ADDR_ACK: begin
          bit_cnt <= 3'h0;
          tx      <= read_byte;
          state   <= rw ? tsr_pkg::LS_RDATA : tsr_pkg::LS_CMD;
        end
        tsr_pkg::LS_CMD: begin
          if (bit_cnt == 3'h7) begin
            ptr_byte <= {shift[6:0], I_SMBDATA};
            ptr_tgl  <= ~ptr_tgl;
            state    <= tsr_pkg::LS_CMD_ACK;
          end
        end
        tsr_pkg::LS_CMD_ACK, tsr_pkg::LS_WDATA_ACK: begin
          bit_cnt <= 3'h0;
          state   <= tsr_pkg::LS_WDATA;
        end
        tsr_pkg::LS_WDATA: begin
          if (bit_cnt == 3'h7) begin
            wr_byte <= {shift[6:0], I_SMBDATA};
            wr_tgl  <= ~wr_tgl;
            state   <= tsr_pkg::LS_WDATA_ACK;
          end
        end
        tsr_pkg::LS_RDATA: begin
          tx <= {tx[6:0], 1'b0};
          if (bit_cnt == 3'h7) begin
            state <= tsr_pkg::LS_RDATA_ACK;
          end
        end
        tsr_pkg::LS_RDATA_ACK: begin
          bit_cnt <= 3'h0;
          tx      <= read_byte;
          state   <= I_SMBDATA ? tsr_pkg::LS_IGNORE : tsr_pkg::LS_RDATA;
        end
        default: state <= tsr_pkg::LS_IGNORE;
      endcase
    end
  end

  // Link side: data line drive changes on the falling serial clock
  always_ff @(negedge I_SMBCLK or posedge link_clear) begin
    if (link_clear) begin
      O_SMBDATA_OE <= 1'b0;
    end else begin
      case (state)
        tsr_pkg::LS_ADDR_ACK, tsr_pkg::LS_CMD_ACK, tsr_pkg::LS_WDATA_ACK: O_SMBDATA_OE <= 1'b1;
        tsr_pkg::LS_RDATA: O_SMBDATA_OE <= ~tx[7];
        default:           O_SMBDATA_OE <= 1'b0;
      endcase
    end
  end

  // Start caught on the falling data line while the serial clock is high; no oversampling needed
  always_ff @(negedge I_SMBDATA or posedge link_clear) begin
    if (link_clear) begin
      start_flag <= 1'b0;
    end else if (I_SMBCLK) begin
      start_flag <= 1'b1;
    end
  end

  // Stop caught on the rising data line while the serial clock is high
  always_ff @(posedge I_SMBDATA or posedge link_clear) begin
    if (link_clear) begin
      stop_flag <= 1'b0;
    end else if (I_SMBCLK) begin
      stop_flag <= 1'b1;
    end
  end

  // Pin synchronisers and frame event detection
  always_ff @(posedge I_MCLK) begin
    if (!I_RESET_N) begin
      scl_sync   <= 2'h3;
      sda_sync   <= 2'h3;
      start_sync <= 3'h0;
      stop_sync  <= 3'h0;
    end else begin
      scl_sync   <= {scl_sync[0], I_SMBCLK};
      sda_sync   <= {sda_sync[0], I_SMBDATA};
      start_sync <= {start_sync[1:0], start_flag};
      stop_sync  <= {stop_sync[1:0], stop_flag};
    end
  end

  // Frame events: rising edge of each synchronised flag, one cycle long
  assign start_det   = start_sync[1] && !start_sync[2];
  assign stop_det    = stop_sync[1] && !stop_sync[2];
  assign line_low    = !scl_sync[1] || !sda_sync[1];
  assign timeout_hit = line_low && (low_cnt == CNT_W'(TIMEOUT_CYCLES - 1));

  // Low-line timer
  always_ff @(posedge I_MCLK) begin
    if (!I_RESET_N || !line_low) begin
      low_cnt <= '0;
    end else if (!timeout_hit) begin
      low_cnt <= CNT_W'(low_cnt + 1'b1);
    end
  end

  // Link clear and frame tracking
  always_ff @(posedge I_MCLK) begin
    if (!I_RESET_N) begin
      link_clear <= 1'b1;
      in_frame   <= 1'b0;
    end else begin
      link_clear <= start_det || stop_det || timeout_hit;
      if (start_det) begin
        in_frame <= 1'b1;
      end else if (stop_det || timeout_hit) begin
        in_frame <= 1'b0;
      end
    end
  end

  // Toggle synchronisers for pointer and data events
  always_ff @(posedge I_MCLK) begin
    if (!I_RESET_N || link_clear) begin
      ptr_sync <= 3'h0;
      wr_sync  <= 3'h0;
    end else begin
      ptr_sync <= {ptr_sync[1:0], ptr_tgl};
      wr_sync  <= {wr_sync[1:0], wr_tgl};
    end
  end

  assign ptr_evt = ptr_sync[1] ^ ptr_sync[2];
  assign wr_evt  = wr_sync[1] ^ wr_sync[2];

  // Pointer and write request capture
  always_ff @(posedge I_MCLK) begin
    if (!I_RESET_N) begin
      pointer     <= tsr_pkg::RST_ZERO;
      wr_req      <= '0;
      wr_valid    <= 1'b0;
      refresh     <= 1'b0;
      drive_level <= 1'b0;
    end else begin
      if (ptr_evt) begin
        pointer <= ptr_byte;
      end
      wr_req      <= '{pointer: pointer, data: wr_byte};
      wr_valid    <= wr_evt;
      refresh     <= ptr_evt || wr_valid;
      drive_level <= 1'b0;
    end
  end

  // Settings registers
  always_ff @(posedge I_MCLK) begin
    if (!I_RESET_N) begin
      config_reg   <= tsr_pkg::RST_ZERO;
      conv_rate    <= tsr_pkg::RST_RATE;
      lhigh_lim    <= tsr_pkg::RST_HIGH;
      rhigh_up     <= tsr_pkg::RST_HIGH;
      llow_lim     <= tsr_pkg::RST_ZERO;
      rlow_up      <= tsr_pkg::RST_ZERO;
      ofs_up       <= tsr_pkg::RST_ZERO;
      ofs_lo       <= tsr_pkg::RST_ZERO;
      rhigh_lo     <= tsr_pkg::RST_ZERO;
      rlow_lo      <= tsr_pkg::RST_ZERO;
      rcrit_lim    <= tsr_pkg::RST_RCRIT;
      lcrit_lim    <= tsr_pkg::RST_LCRIT;
      hyst         <= tsr_pkg::RST_HYST;
      filter_setup <= tsr_pkg::RST_ZERO;
    end else if (wr_valid) begin
      if (wr_req.pointer == tsr_pkg::WR_CONFIG) begin
        config_reg <= wr_req.data & tsr_pkg::CFG_DEFINED;
      end else if (wr_req.pointer == tsr_pkg::WR_RATE) begin
        conv_rate <= wr_req.data;
      end else if (wr_req.pointer == tsr_pkg::WR_LHIGH) begin
        lhigh_lim <= wr_req.data;
      end else if (wr_req.pointer == tsr_pkg::WR_LLOW) begin
        llow_lim <= wr_req.data;
      end else if (wr_req.pointer == tsr_pkg::WR_RHIGH_UP) begin
        rhigh_up <= wr_req.data;
      end else if (wr_req.pointer == tsr_pkg::WR_RLOW_UP) begin
        rlow_up <= wr_req.data;
      end else if (wr_req.pointer == tsr_pkg::RW_OFS_UP) begin
        ofs_up <= wr_req.data;
      end else if (wr_req.pointer == tsr_pkg::RW_OFS_LO) begin
        ofs_lo <= wr_req.data;
      end else if (wr_req.pointer == tsr_pkg::RW_RHIGH_LO) begin
        rhigh_lo <= wr_req.data;
      end else if (wr_req.pointer == tsr_pkg::RW_RLOW_LO) begin
        rlow_lo <= wr_req.data;
      end else if (wr_req.pointer == tsr_pkg::RW_RCRIT) begin
        rcrit_lim <= wr_req.data;
      end else if (wr_req.pointer == tsr_pkg::RW_LCRIT) begin
        lcrit_lim <= wr_req.data;
      end else if (wr_req.pointer == tsr_pkg::RW_HYST) begin
        hyst <= wr_req.data[4:0];
      end else if (wr_req.pointer == tsr_pkg::RW_FILTER) begin
        filter_setup <= wr_req.data & tsr_pkg::FILT_DEFINED;
      end
    end
  end

  // Read decode; test range, one-shot and unmapped addresses read zero
  always_comb begin
    if (pointer == tsr_pkg::RD_LOCAL) begin
      next_read_byte = local_temp;
    end else if (pointer == tsr_pkg::RD_REM_UP) begin
      next_read_byte = remote_filt[10:3];
    end else if (pointer == tsr_pkg::RD_STATUS) begin
      next_read_byte = status;
    end else if (pointer == tsr_pkg::RD_REM_LO) begin
      next_read_byte = {remote_filt[2:0], 5'h00};
    end else if (pointer == tsr_pkg::RD_CONFIG) begin
      next_read_byte = config_reg;
    end else if (pointer == tsr_pkg::RD_RATE) begin
      next_read_byte = conv_rate;
    end else if (pointer == tsr_pkg::RD_LHIGH) begin
      next_read_byte = lhigh_lim;
    end else if (pointer == tsr_pkg::RD_LLOW) begin
      next_read_byte = llow_lim;
    end else if (pointer == tsr_pkg::RD_RHIGH_UP) begin
      next_read_byte = rhigh_up;
    end else if (pointer == tsr_pkg::RD_RLOW_UP) begin
      next_read_byte = rlow_up;
    end else if (pointer == tsr_pkg::RW_OFS_UP) begin
      next_read_byte = ofs_up;
    end else if (pointer == tsr_pkg::RW_OFS_LO) begin
      next_read_byte = ofs_lo;
    end else if (pointer == tsr_pkg::RW_RHIGH_LO) begin
      next_read_byte = rhigh_lo;
    end else if (pointer == tsr_pkg::RW_RLOW_LO) begin
      next_read_byte = rlow_lo;
    end else if (pointer == tsr_pkg::RW_RCRIT) begin
      next_read_byte = rcrit_lim;
    end else if (pointer == tsr_pkg::RW_LCRIT) begin
      next_read_byte = lcrit_lim;
    end else if (pointer == tsr_pkg::RW_HYST) begin
      next_read_byte = {3'h0, hyst};
    end else if (pointer == tsr_pkg::RW_FILTER) begin
      next_read_byte = filter_setup;
    end else if (pointer == tsr_pkg::RD_MAKER) begin
      next_read_byte = MAKER_CODE;
    end else if (pointer == tsr_pkg::RD_REVISION) begin
      next_read_byte = REVISION_CODE;
    end else begin
      next_read_byte = 8'h00;
    end
  end

  // Read byte held still inside a frame except right after a pointer or write event
  always_ff @(posedge I_MCLK) begin
    if (!I_RESET_N) begin
      read_byte <= 8'h00;
    end else if (!in_frame || refresh) begin
      read_byte <= next_read_byte;
    end
  end

  // One-shot request; a new write wins over the clearing sample
  always_ff @(posedge I_MCLK) begin
    if (!I_RESET_N) begin
      oneshot_pending <= 1'b0;
      O_CONVERT_REQ   <= 1'b0;
    end else begin
      if (wr_valid && wr_req.pointer == tsr_pkg::WR_ONESHOT) begin
        oneshot_pending <= 1'b1;
      end else if (I_SAMPLE_VALID) begin
        oneshot_pending <= 1'b0;
      end
      O_CONVERT_REQ <= !config_reg[tsr_pkg::CFG_STANDBY] || (oneshot_pending && !I_SAMPLE_VALID)
                       || (wr_valid && wr_req.pointer == tsr_pkg::WR_ONESHOT);
    end
  end

  // Offset addition, saturation and noise filter
  always_comb begin
    adj_sum = 12'($signed({I_REMOTE_SAMPLE[10], I_REMOTE_SAMPLE}) + $signed({ofs_up[7], ofs_up, ofs_lo[7:5]}));
    if ($signed(adj_sum) > $signed(12'h3FF)) begin
      remote_adj = 11'h3FF;
    end else if ($signed(adj_sum) < $signed(12'hC00)) begin
      remote_adj = 11'h400;
    end else begin
      remote_adj = adj_sum[10:0];
    end
    diff = 12'({remote_adj[10], remote_adj} - {remote_filt[10], remote_filt});
    case (filter_setup[tsr_pkg::FILT_LSB +: 2])
      2'h0:    step = diff;
      2'h3:    step = 12'($signed(diff) >>> 2);
      default: step = 12'($signed(diff) >>> 1);
    endcase
    if (step == 12'h000 && diff != 12'h000) begin
      step = diff[11] ? 12'hFFF : 12'h001;
    end
    next_remote = 11'(remote_filt + step[10:0]);
  end

  // Limit comparisons on the new readings, critical with hysteresis
  always_comb begin
    r_high = $signed(next_remote) > $signed({rhigh_up, rhigh_lo[7:5]});
    r_low  = $signed(next_remote) < $signed({rlow_up, rlow_lo[7:5]});
    r_crit = status.rcrit ? $signed({next_remote[10], next_remote[10:3]})
                            > $signed(9'({rcrit_lim[7], rcrit_lim} - {4'h0, hyst}))
                          : $signed(next_remote[10:3]) > $signed(rcrit_lim);
    r_any  = r_high || r_low || r_crit;
    l_high = $signed(I_LOCAL_SAMPLE) > $signed(lhigh_lim);
    l_low  = $signed(I_LOCAL_SAMPLE) < $signed(llow_lim);
    l_crit = status.lcrit ? $signed({I_LOCAL_SAMPLE[7], I_LOCAL_SAMPLE})
                            > $signed(9'({lcrit_lim[7], lcrit_lim} - {4'h0, hyst}))
                          : $signed(I_LOCAL_SAMPLE) > $signed(lcrit_lim);
  end

  // Readings, fault queue and status flags
  always_ff @(posedge I_MCLK) begin
    if (!I_RESET_N) begin
      local_temp  <= 8'h00;
      remote_filt <= 11'h000;
      fault_cnt   <= 2'h0;
      status      <= '0;
    end else begin
      status.busy <= O_CONVERT_REQ;
      if (I_SAMPLE_VALID) begin
        local_temp   <= I_LOCAL_SAMPLE;
        remote_filt  <= next_remote;
        status.open  <= I_REMOTE_OPEN;
        status.lhigh <= l_high;
        status.llow  <= l_low;
        status.lcrit <= l_crit;
        fault_cnt    <= r_any ? ((fault_cnt == 2'h3) ? 2'h3 : 2'(fault_cnt + 2'h1)) : 2'h0;
        if (!config_reg[tsr_pkg::CFG_QUEUE] || fault_cnt >= tsr_pkg::QUEUE_LAST || !r_any) begin
          status.rhigh <= r_high;
          status.rlow  <= r_low;
          status.rcrit <= r_crit;
        end
      end
    end
  end

  // Open-drain pins: drive low on an unmasked alarm
  always_ff @(posedge I_MCLK) begin
    if (!I_RESET_N) begin
      O_ALERT_OE <= 1'b0;
      O_TCRIT_OE <= 1'b0;
    end else begin
      O_ALERT_OE <= !config_reg[tsr_pkg::CFG_AMASK] && (status.lhigh || status.llow || status.rhigh
                    || status.rlow || status.rcrit || status.lcrit);
      O_TCRIT_OE <= (status.rcrit && !config_reg[tsr_pkg::CFG_RMASK])
                    || (status.lcrit && !config_reg[tsr_pkg::CFG_LMASK]);
    end
  end

  assign O_SMBDATA_OUT = drive_level;
  assign O_ALERT_OUT   = drive_level;
  assign O_TCRIT_OUT   = drive_level;

  default clocking cb @(posedge I_MCLK); endclocking
  default disable iff (!I_RESET_N);

  sequence s_oneshot_write;
    wr_valid && wr_req.pointer == tsr_pkg::WR_ONESHOT;
  endsequence
  sequence s_pointer_then_refresh;
    ptr_evt ##1 refresh;
  endsequence

  AST_TIMEOUT_CLEAR: assert property (line_low && low_cnt == CNT_W'(TIMEOUT_CYCLES - 1) |=> link_clear && !in_frame)
    else $error("Timeout did not clear the link");
  AST_START_CLEAR: assert property (start_det |=> link_clear && in_frame)
    else $error("Start did not restart the link");
  AST_RESET_VALUES: assert property ($rose(I_RESET_N) |-> config_reg == 8'h00 && conv_rate == 8'h08
    && rhigh_up == 8'h46 && lhigh_lim == 8'h46 && rcrit_lim == 8'h6E && lcrit_lim == 8'h55 && hyst == 5'h0A
    && filter_setup == 8'h00 && pointer == 8'h00)
    else $error("Wrong power-on register value");
  AST_ONESHOT_SET: assert property (s_oneshot_write |=> oneshot_pending ##1 O_CONVERT_REQ)
    else $error("One-shot write lost");
  AST_ONESHOT_DONE: assert property (oneshot_pending && config_reg[6] && I_SAMPLE_VALID && !wr_valid
    |=> !oneshot_pending ##1 !O_CONVERT_REQ)
    else $error("One-shot ran more than one conversion");
  AST_ONESHOT_READ: assert property (s_pointer_then_refresh ##0 (ptr_byte == 8'h0F) |=> read_byte == 8'h00)
    else $error("One-shot location read nonzero");
  AST_SPLIT_RATE: assert property (wr_valid && wr_req.pointer == 8'h0A |=> conv_rate == $past(wr_req.data))
    else $error("Rate write not seen at read side");
  AST_FILTER_OFF: assert property (I_SAMPLE_VALID && filter_setup[2:1] == 2'h0 |=> remote_filt == $past(remote_adj))
    else $error("Unfiltered reading differs");
  AST_QUEUE_HOLD: assert property (I_SAMPLE_VALID && config_reg[0] && r_any && fault_cnt < 2'h2
    |=> $stable({status.rhigh, status.rlow, status.rcrit}))
    else $error("Remote alarm before third fault");
endmodule

// ==== verif/smb_host.sv ====
// SMBus host model for the serial link
`timescale 1ns/1ps
module smb_host (
  // Serial link
  input  wire logic i_sda,
  output logic      o_scl,
  output logic      o_sda_low
);
  // Idle bus: clock high, data released
  initial begin
    o_scl = 1'b1;
    o_sda_low = 1'b0;
  end
  // One bit, data moved only while clock low
  task automatic bit_cyc(input logic b, output logic q);
    #3 o_sda_low = ~b;
    #3 o_scl = 1'b1;
    #3 q = i_sda;
    #3 o_scl = 1'b0;
  endtask
  // Start or repeated start, clock then stands still
  task automatic start();
    #3 o_sda_low = 1'b0;
    #3 o_scl = 1'b1;
    #1000 o_sda_low = 1'b1;
    #1000 o_scl = 1'b0;
  endtask
  // Stop, leaving the bus idle
  task automatic stop();
    #3 o_sda_low = 1'b1;
    #3 o_scl = 1'b1;
    #1000 o_sda_low = 1'b0;
    #1000;
  endtask
  // Byte MSB first plus ack slot
  task automatic xfer(input logic [7:0] b, input logic a, output logic [7:0] q);
    logic x;
    for (int i = 7; i >= 0; i--) bit_cyc(b[i], q[i]);
    bit_cyc(a, x);
  endtask
endmodule

// ==== verif/tb_top.sv ====
// Self-checking bench of the temperature sensor serial register block
`timescale 1ns/1ps
module tb_top;
  logic        mclk, reset_n, valid, scl, hlow, oe, creq, aoe, toe;
  logic [7:0]  r;
  logic [10:0] rs;
  int          failures, n_checks;
  wire         sda = ~(hlow | oe);
  localparam logic [15:0] RT[21] = '{'h0000, 'h0100, 'h1000, 'h0300, 'h0408, 'h0546, 'h0600, 'h0746,
    'h0800, 'h1100, 'h1200, 'h1300, 'h1400, 'h196E, 'h2055, 'h210A, 'hBF00, 'hFE5A, 'hFFA5, 'h0F00, 'hB500};
  localparam logic [31:0] WT[17] = '{'h09030101, 'h0A040505, 'h0B055050, 'h0C06F6F6, 'h0D074040,
    'h0E081010, 'h11110202, 'h1212E0E0, 'h1313A0A0, 'h14146060, 'h19197070, 'h20205050, 'h2121FF1F,
    'hBFBFFF07, 'hB5B5FF00, 'h00003300, 'h0F0F7700};
  smb_host i_smb_host (.i_sda(sda), .o_scl(scl), .o_sda_low(hlow));
  temp_sensor_smbus_regs #(.TIMEOUT_CYCLES(200)) i_temp_sensor_smbus_regs (.I_MCLK(mclk), .I_RESET_N(reset_n),
    .I_SMBCLK(scl), .I_SMBDATA(sda), .O_SMBDATA_OUT(), .O_SMBDATA_OE(oe), .I_SAMPLE_VALID(valid),
    .I_LOCAL_SAMPLE(8'h19), .I_REMOTE_SAMPLE(rs), .I_REMOTE_OPEN(1'b0), .O_CONVERT_REQ(creq),
    .O_ALERT_OUT(), .O_ALERT_OE(aoe), .O_TCRIT_OUT(), .O_TCRIT_OE(toe));
  // 40 MHz system clock
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  task automatic chk(input logic [7:0] g, e);
    n_checks++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED %0t got %h want %h", $time, g, e);
    end
  endtask
  // Register access over the link
  task automatic rdcur(input logic [7:0] e);
    i_smb_host.start();
    i_smb_host.xfer(8'h99, 1'b1, r);
    i_smb_host.xfer(8'hFF, 1'b1, r);
    i_smb_host.stop();
    chk(r, e);
  endtask
  task automatic wr(input logic [7:0] p, d, input logic go = 1'b1);
    i_smb_host.start();
    i_smb_host.xfer(8'h98, 1'b1, r);
    i_smb_host.xfer(p, 1'b1, r);
    if (go) i_smb_host.xfer(d, 1'b1, r);
    if (go) i_smb_host.stop();
  endtask
  task automatic rd(input logic [7:0] p, e);
    wr(p, 8'h00, 1'b0);
    rdcur(e);
  endtask
  task automatic smp(input logic [10:0] v, input int n);
    repeat (n) begin
      @(posedge mclk) #1 {valid, rs} = {1'b1, v};
      @(posedge mclk) #1 valid = 1'b0;
    end
  endtask
  task automatic t_reset();
    rdcur(8'h00);
    foreach (RT[i]) rd(RT[i][15:8], RT[i][7:0]);
  endtask
  task automatic t_rw();
    foreach (WT[i]) begin
      wr(WT[i][31:24], WT[i][15:8]);
      rd(WT[i][23:16], WT[i][7:0]);
    end
  endtask
  task automatic t_filt();
    logic [10:0] e;
    for (int k = 3; k >= 0; k--) begin
      wr(8'hBF, 8'(k << 1));
      smp(11'(203 + 40 * k), k == 0 ? 1 : 40);
      e = 11'(226 + 40 * k);
      rd(8'h01, e[10:3]);
      rd(8'h10, {e[2:0], 5'h00});
    end
  endtask
  task automatic t_queue();
    for (int i = 1; i <= 3; i++) begin
      smp(11'h320, 1);
      repeat (2) @(posedge mclk);
      chk(8'(aoe), 8'(i == 3));
    end
    wr(8'h09, 8'h00);
    smp(11'h0C8, 1);
    smp(11'h320, 1);
    repeat (2) @(posedge mclk);
    chk(8'(aoe), 8'h01);
    smp(11'h3E0, 1);
    repeat (2) @(posedge mclk);
    chk(8'(toe), 8'h01);
    rd(8'h02, 8'h92);
  endtask
  task automatic t_bus();
    rd(8'h04, 8'h05);
    i_smb_host.start();
    i_smb_host.xfer(8'h99, 1'b1, r);
    #3 chk(8'(oe), 8'h01);
    #6000 chk(8'(oe), 8'h00);
    wr(8'h04, 8'h00, 1'b0);
    for (int i = 0; i < 3; i++) i_smb_host.bit_cyc(1'b0, r[0]);
    rdcur(8'h05);
  endtask
  task automatic t_shot();
    wr(8'h09, 8'h40);
    smp(11'h0C8, 1);
    repeat (2) @(posedge mclk);
    chk(8'(creq), 8'h00);
    wr(8'h0F, 8'hFF);
    chk(8'(creq), 8'h01);
    smp(11'h0C8, 1);
    repeat (20) @(posedge mclk);
    chk(8'(creq), 8'h00);
  endtask
  // Main sequence
  initial begin
    {reset_n, valid, rs} = '0;
    repeat (8) @(posedge mclk);
    #1 reset_n = 1'b1;
    repeat (4) @(posedge mclk);
    t_reset();
    t_rw();
    t_filt();
    t_queue();
    t_bus();
    t_shot();
    test_done();
  end
  // Watchdog
  initial begin
    #2000000 failures++;
    test_done();
  end
  task automatic test_done();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
endmodule
